// file: inc/lpms_pkg.sv
package lpms_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 10;        // 100 MHz bus clock
  localparam int unsigned WAKE_CLK_PERIOD_NS = 1_000_000; // about 1 kHz
  localparam int unsigned WAKE_TICK_CYCLES   =
    WAKE_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  RESET_SEQ_LAST     = 8'h0F;     // 16 cycles held

  // ------------------------------------------------------------------
  // widths, vector and reset values
  // ------------------------------------------------------------------
  localparam int unsigned PIN_W   = 8;
  localparam int unsigned RTIS_W  = 3;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 32;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
  localparam logic [7:0]  PORT_DATA_RST     = 8'h00;
  localparam logic [7:0]  PERIPH_EN_RST     = 8'h00;
  localparam logic [2:0]  RTIS_RST          = 3'h0;
  localparam logic [2:0]  RTIS_OFF          = 3'h0;
  localparam logic        LVD_EN_RST        = 1'b0;
  localparam logic        LVD_STOP_RST      = 1'b0;
  localparam logic        SEL_LATCHED_RST   = 1'b0;
  localparam logic        IRQ_POL_RST       = 1'b0;

  // ------------------------------------------------------------------
  // register map (byte addresses) and field positions
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_POWER   = 4'h4; // power_mgmt_status_control_two
  localparam logic [3:0] OFS_PORT    = 4'h8;
  localparam logic [3:0] OFS_PERIPH  = 4'hC;

  localparam int unsigned CTL_LVD_EN_BIT      = 0;
  localparam int unsigned CTL_LVD_STOP_BIT    = 1;
  localparam int unsigned CTL_SEL_LATCHED_BIT = 2;
  localparam int unsigned CTL_IRQ_POL_BIT     = 3;
  localparam int unsigned CTL_RTIS_LSB        = 4;
  localparam int unsigned PWR_FLAG_BIT        = 0;
  localparam int unsigned PWR_ACK_BIT         = 1;
  localparam int unsigned PWR_STATE_LSB       = 4;

  // ------------------------------------------------------------------
  // states and debug commands
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_LATCHED_DEEP_SLEEP = 3'b011,
    ST_RETAINED_DEEP_SLEEP = 3'b100,
    ST_BDM   = 3'b101
  } lpms_state_t;

  typedef enum logic [1:0] {
    DBG_HALT       = 2'b00,
    DBG_MEM_STATUS = 2'b01,
    DBG_OTHER      = 2'b10
  } lpms_dbg_cmd_t;

endpackage

// file: src/lpms_sync3.sv
`timescale 1ns/10ps
module lpms_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic mclk_in,   // bus clock
  input  wire logic reset_in,  // synchronous reset, active high
  input  wire logic async_in,  // pin from outside the clock domain
  output logic      level_out  // filtered level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } lpms_sync_t;

  lpms_sync_t sync_reg;
  lpms_sync_t sync_next;

  // ------------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  // ------------------------------------------------------------------
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = async_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    if (sync_reg.s2 == sync_reg.s3) begin
      sync_next.lvl = sync_reg.s3;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sync_reg <= {4{RESET_VAL}};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level_out = sync_reg.lvl;

endmodule // lpms_sync3

// file: src/lpms_tick_div.sv
`timescale 1ns/10ps
module lpms_tick_div #(
  parameter int unsigned TICKS = 100000
) (
  input  wire logic mclk_in,   // bus clock
  input  wire logic reset_in,  // synchronous reset, active high
  input  wire logic enable_in, // source runs while high
  output logic      tick_out   // one-cycle pulse per period
);

  localparam int unsigned W = (TICKS > 1) ? $clog2(TICKS) : 1;
  localparam logic [W-1:0] LAST = W'(TICKS - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } lpms_div_t;

  lpms_div_t div_reg;
  lpms_div_t div_next;

  // ------------------------------------------------------------------
  // free divider; held cleared while disabled to save power
  // ------------------------------------------------------------------
  always_comb begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (!enable_in) begin
      div_next.cnt = '0;
    end else if (div_reg.cnt == LAST) begin
      div_next.cnt  = '0;
      div_next.tick = 1'b1;
    end else begin
      div_next.cnt = div_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick_out = div_reg.tick;

endmodule // lpms_tick_div

// file: src/lpms_sequencer.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
module lpms_sequencer
  import lpms_pkg::*;
#(
  parameter int unsigned WAKE_TICKS = lpms_pkg::WAKE_TICK_CYCLES
) (
  input  wire logic                            mclk_in,          // clock
  input  wire logic                            reset_in,         // sync rst
  // avalon-mm slave
  input  wire logic [lpms_pkg::ADDR_W-1:0]     avs_address_in,   // byte adr
  input  wire logic                            avs_read_in,      // read
  input  wire logic                            avs_write_in,     // write
  input  wire logic [lpms_pkg::DATA_W-1:0]     avs_writedata_in, // wr data
  output logic      [lpms_pkg::DATA_W-1:0]     avs_readdata_out, // rd data
  output logic                                 avs_waitrequest_out, // stall
  // pins
  input  wire logic                            mode_select_pin_in, // strap
  input  wire logic                            ext_reset_pin_n_in, // reset
  input  wire logic                            ext_irq_pin_in,   // irq pin
  // cpu core
  input  wire logic                            cpu_wait_in,      // wait op
  input  wire logic                            cpu_stop_in,      // stop op
  input  wire logic                            cpu_irq_req_in,   // any irq
  output logic                                 cpu_clk_en_out,   // clk gate
  output logic                                 cpu_reset_out,    // held rst
  output logic      [15:0]                     reset_vector_out, // vector
  output logic                                 clr_imask_out,    // pulse
  output logic                                 stack_go_out,     // pulse
  output logic                                 run_mode_out,     // run
  output logic                                 bdm_out,          // bg mode
  output logic                                 wake_irq_out,     // pulse
  // debug port
  input  wire logic                            dbg_valid_in,     // command
  input  wire lpms_pkg::lpms_dbg_cmd_t         dbg_cmd_in,       // kind
  output logic                                 dbg_ack_out,      // taken
  output logic                                 dbg_err_out,      // stop err
  output logic                                 dbg_mem_go_out,   // access
  // power and pins
  output logic                                 core_off_out,     // off
  output logic                                 reg_stby_out,     // stdby
  output logic                                 adc_stby_out,     // stdby
  output logic                                 pin_hold_out,     // latched
  input  wire logic [lpms_pkg::PIN_W-1:0]      periph_pin_in,    // periph
  output logic      [lpms_pkg::PIN_W-1:0]      pin_out           // to pads
);
  typedef struct packed {
    lpms_state_t       st;
    logic [7:0]        rst_cnt;
    logic              run_mode;
    logic              bdm;
    logic              cpu_clk_en;
    logic              cpu_rst;
    logic [15:0]       vec;
    logic              clr_imask;
    logic              stack_go;
    logic              lvd_en;
    logic              lvd_stop_en;
    logic              sel_latched;
    logic              irq_pol;
    logic [RTIS_W-1:0] rtis;
    logic [7:0]        tick_cnt;
    logic              wake_irq;
    logic [PIN_W-1:0]  port_data;
    logic [PIN_W-1:0]  periph_en;
    logic [PIN_W-1:0]  latch;
    logic [PIN_W-1:0]  pins;
    logic              hold;
    logic              flag;
    logic              dbg_ack;
    logic              dbg_err;
    logic              dbg_mem;
    logic              core_off;
    logic              reg_stby;
    logic              adc_stby;
    logic              waitreq;
    logic [DATA_W-1:0] rdata;
  } lpms_top_t;
  lpms_top_t seq_reg;
  lpms_top_t seq_next;
  logic ms_lvl;
  logic rstpin_n_lvl;
  logic irqpin_lvl;
  logic wake_tick;
  // ------------------------------------------------------------------
  // pin synchronisers and the 1 kHz wake source
  // ------------------------------------------------------------------
  lpms_sync3 #(.RESET_VAL(1'b1)) u_sync_ms (
    .mclk_in   (mclk_in),  .reset_in  (reset_in),
    .async_in  (mode_select_pin_in),
    .level_out (ms_lvl)
  );
  lpms_sync3 #(.RESET_VAL(1'b1)) u_sync_rst (
    .mclk_in   (mclk_in),  .reset_in  (reset_in),
    .async_in  (ext_reset_pin_n_in),
    .level_out (rstpin_n_lvl)
  );
  lpms_sync3 #(.RESET_VAL(1'b1)) u_sync_irq (
    .mclk_in   (mclk_in),  .reset_in  (reset_in),
    .async_in  (ext_irq_pin_in),
    .level_out (irqpin_lvl)
  );
  // source stopped when the interval field is zero
  lpms_tick_div #(.TICKS(WAKE_TICKS)) u_wake_div (
    .mclk_in   (mclk_in),  .reset_in  (reset_in),
    .enable_in (seq_reg.rtis != RTIS_OFF),
    .tick_out  (wake_tick)
  );
  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic              irq_cfg;
    logic              rti_fire;
    logic              stop_lvd_on;
    logic [7:0]        tick_target;
    logic [DATA_W-1:0] rd;
    irq_cfg     = irqpin_lvl ~^ seq_reg.irq_pol;
    rti_fire    = 1'b0;
    stop_lvd_on = seq_reg.lvd_en && seq_reg.lvd_stop_en;
    tick_target = 8'(8'h01 << seq_reg.rtis);
    rd          = '0;
    seq_next           = seq_reg;
    seq_next.clr_imask = 1'b0;
    seq_next.stack_go  = 1'b0;
    seq_next.dbg_ack   = 1'b0;
    seq_next.dbg_err   = 1'b0;
    seq_next.dbg_mem   = 1'b0;
    seq_next.wake_irq  = 1'b0;
    seq_next.waitreq   = 1'b1;
    // periodic wake: 2^select ticks of the slow source per interrupt
    if (seq_reg.rtis == RTIS_OFF) begin
      seq_next.tick_cnt = '0;
    end else if (wake_tick) begin
      if (seq_reg.tick_cnt + 8'h01 >= tick_target) begin
        seq_next.tick_cnt = '0;
        seq_next.wake_irq = 1'b1;
        rti_fire          = 1'b1;
      end else begin
        seq_next.tick_cnt = seq_reg.tick_cnt + 8'h01;
      end
    end
    // bus slave: one wait cycle, then answer at the following edge
    if ((avs_read_in || avs_write_in) && seq_reg.waitreq) begin
      seq_next.waitreq = 1'b0;
      unique case (avs_address_in)
        OFS_CONTROL: begin
          rd[CTL_LVD_EN_BIT]         = seq_reg.lvd_en;
          rd[CTL_LVD_STOP_BIT]       = seq_reg.lvd_stop_en;
          rd[CTL_SEL_LATCHED_BIT]    = seq_reg.sel_latched;
          rd[CTL_IRQ_POL_BIT]        = seq_reg.irq_pol;
          rd[CTL_RTIS_LSB +: RTIS_W] = seq_reg.rtis;
        end
        OFS_POWER: begin
          rd[PWR_FLAG_BIT]     = seq_reg.flag;
          rd[PWR_ACK_BIT]      = 1'b0;
          rd[PWR_STATE_LSB +: 3] = seq_reg.st;
        end
        OFS_PORT:   rd[PIN_W-1:0] = seq_reg.port_data;
        OFS_PERIPH: rd[PIN_W-1:0] = seq_reg.periph_en;
        default:    rd = '0;
      endcase
      if (avs_read_in) begin
        seq_next.rdata = rd;
      end
      if (avs_write_in) begin
        unique case (avs_address_in)
          OFS_CONTROL: begin
            seq_next.lvd_en      = avs_writedata_in[CTL_LVD_EN_BIT];
            seq_next.lvd_stop_en = avs_writedata_in[CTL_LVD_STOP_BIT];
            seq_next.sel_latched = avs_writedata_in[CTL_SEL_LATCHED_BIT];
            seq_next.irq_pol     = avs_writedata_in[CTL_IRQ_POL_BIT];
            seq_next.rtis = avs_writedata_in[CTL_RTIS_LSB +: RTIS_W];
          end
          OFS_POWER: begin
            // only a one opens the latches and clears the flag
            if (avs_writedata_in[PWR_ACK_BIT]) begin
              seq_next.flag = 1'b0;
              seq_next.hold = 1'b0;
            end
          end
          OFS_PORT:   seq_next.port_data = avs_writedata_in[PIN_W-1:0];
          OFS_PERIPH: seq_next.periph_en = avs_writedata_in[PIN_W-1:0];
          default: ;
        endcase
      end
    end
    // debug commands; restricted while the cpu sleeps
    if (dbg_valid_in) begin
      unique case (seq_reg.st)
        ST_WAIT, ST_LATCHED_DEEP_SLEEP, ST_RETAINED_DEEP_SLEEP: begin
          if (dbg_cmd_in == DBG_MEM_STATUS) begin
            seq_next.dbg_ack = 1'b1;
            seq_next.dbg_err = 1'b1;
          end else if (dbg_cmd_in == DBG_HALT && seq_reg.st == ST_WAIT) begin
            seq_next.dbg_ack = 1'b1;
          end
        end
        ST_RUN, ST_BDM: begin
          seq_next.dbg_ack = 1'b1;
          seq_next.dbg_mem = (dbg_cmd_in == DBG_MEM_STATUS);
        end
        default: ;
      endcase
    end
    // operating-mode sequence
    unique case (seq_reg.st)
      ST_RESET: begin
        // peripherals back to defaults; latches and flag survive
        seq_next.cpu_rst     = 1'b1;
        seq_next.cpu_clk_en  = 1'b0;
        seq_next.bdm         = 1'b0;
        seq_next.core_off    = 1'b0;
        seq_next.reg_stby    = 1'b0;
        seq_next.adc_stby    = 1'b0;
        seq_next.lvd_en      = LVD_EN_RST;
        seq_next.lvd_stop_en = LVD_STOP_RST;
        seq_next.sel_latched = SEL_LATCHED_RST;
        seq_next.irq_pol     = IRQ_POL_RST;
        seq_next.rtis        = RTIS_RST;
        seq_next.port_data   = PORT_DATA_RST;
        seq_next.periph_en   = PERIPH_EN_RST;
        if (seq_reg.rst_cnt == RESET_SEQ_LAST) begin
          // strap taken as the reset is released
          seq_next.st         = ms_lvl ? ST_RUN : ST_BDM;
          seq_next.run_mode   = ms_lvl;
          seq_next.bdm        = !ms_lvl;
          seq_next.cpu_rst    = 1'b0;
          seq_next.cpu_clk_en = 1'b1;
          seq_next.vec        = RESET_VECTOR_ADDR;
        end else begin
          seq_next.rst_cnt = seq_reg.rst_cnt + 8'h01;
        end
      end
      ST_RUN: begin
        if (cpu_wait_in) begin
          seq_next.st         = ST_WAIT;
          seq_next.cpu_clk_en = 1'b0;
          seq_next.clr_imask  = 1'b1;
        end else if (cpu_stop_in) begin
          seq_next.cpu_clk_en = 1'b0;
          seq_next.reg_stby   = 1'b1;
          seq_next.adc_stby   = 1'b1;
          if (seq_reg.sel_latched && !stop_lvd_on) begin
            seq_next.st       = ST_LATCHED_DEEP_SLEEP;
            seq_next.core_off = 1'b1;
            seq_next.latch    = seq_reg.pins;
            seq_next.hold     = 1'b1;
          end else begin
            // retained sleep keeps every register; pins are not latched and still follow port and peripheral
            seq_next.st = ST_RETAINED_DEEP_SLEEP;
          end
        end
      end
      ST_WAIT: begin
        if (dbg_valid_in && dbg_cmd_in == DBG_HALT) begin
          seq_next.st         = ST_BDM;
          seq_next.bdm        = 1'b1;
          seq_next.cpu_clk_en = 1'b1;
        end else if (cpu_irq_req_in || rti_fire) begin
          seq_next.st         = ST_RUN;
          seq_next.cpu_clk_en = 1'b1;
          seq_next.stack_go   = 1'b1;
        end
      end
      ST_LATCHED_DEEP_SLEEP: begin
        // pin is low-true here whatever polarity was programmed
        if (!irqpin_lvl || rti_fire) begin
          seq_next.st      = ST_RESET;
          seq_next.rst_cnt = '0;
          seq_next.cpu_rst = 1'b1;
          seq_next.flag    = 1'b1;
        end
      end
      ST_RETAINED_DEEP_SLEEP: begin
        if (irq_cfg || rti_fire) begin
          seq_next.st         = ST_RUN;
          seq_next.cpu_clk_en = 1'b1;
          seq_next.stack_go   = 1'b1;
          seq_next.reg_stby   = 1'b0;
          seq_next.adc_stby   = 1'b0;
        end
      end
      ST_BDM: seq_next.cpu_clk_en = 1'b1;
      default: begin
        seq_next.st      = ST_RESET;
        seq_next.rst_cnt = '0;
      end
    endcase
    // external reset pin restarts the sequence from any state
    if (!rstpin_n_lvl) begin
      if (seq_reg.st == ST_LATCHED_DEEP_SLEEP) begin
        seq_next.flag = 1'b1;
      end
      seq_next.st       = ST_RESET;
      seq_next.rst_cnt  = '0;
      seq_next.cpu_rst  = 1'b1;
      seq_next.run_mode = 1'b0;
    end
    // pads: latched value wins; else peripheral or port register
    if (seq_next.hold) begin
      seq_next.pins = seq_next.hold == seq_reg.hold ?
                      seq_reg.latch : seq_next.latch;
    end else begin
      seq_next.pins = (seq_reg.periph_en & periph_pin_in) |
                      (~seq_reg.periph_en & seq_reg.port_data);
    end
  end
  // ------------------------------------------------------------------
  // state register; flag, latches and held pins survive the reset pin, lost on full reset
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      seq_reg            <= '0;
      seq_reg.st         <= ST_RESET;
      seq_reg.cpu_rst    <= 1'b1;
      seq_reg.vec        <= RESET_VECTOR_ADDR;
      seq_reg.port_data  <= PORT_DATA_RST;
      seq_reg.periph_en  <= PERIPH_EN_RST;
      seq_reg.waitreq    <= 1'b1;
    end else begin
      seq_reg <= seq_next;
    end
  end
  // ------------------------------------------------------------------
  // outputs straight from the state register
  // ------------------------------------------------------------------
  assign avs_readdata_out    = seq_reg.rdata;
  assign avs_waitrequest_out = seq_reg.waitreq;
  assign cpu_clk_en_out      = seq_reg.cpu_clk_en;
  assign cpu_reset_out       = seq_reg.cpu_rst;
  assign reset_vector_out    = seq_reg.vec;
  assign clr_imask_out       = seq_reg.clr_imask;
  assign stack_go_out        = seq_reg.stack_go;
  assign run_mode_out        = seq_reg.run_mode;
  assign bdm_out             = seq_reg.bdm;
  assign wake_irq_out        = seq_reg.wake_irq;
  assign dbg_ack_out         = seq_reg.dbg_ack;
  assign dbg_err_out         = seq_reg.dbg_err;
  assign dbg_mem_go_out      = seq_reg.dbg_mem;
  assign core_off_out        = seq_reg.core_off;
  assign reg_stby_out        = seq_reg.reg_stby;
  assign adc_stby_out        = seq_reg.adc_stby;
  assign pin_hold_out        = seq_reg.hold;
  assign pin_out             = seq_reg.pins;
endmodule // lpms_sequencer

// file: tb/lpms_sequencer_sva.sv
`timescale 1ns/10ps
module lpms_sequencer_sva
  import lpms_pkg::*;
(
  input wire logic                 mclk_in,             // clock
  input wire logic                 reset_in,            // reset
  input wire logic                 avs_read_in,         // read
  input wire logic                 avs_write_in,        // write
  input wire logic                 avs_waitrequest_out, // stall
  input wire logic                 mode_select_pin_in,  // strap
  input wire logic                 dbg_valid_in,        // command
  input wire lpms_pkg::lpms_dbg_cmd_t dbg_cmd_in,       // kind
  input wire logic                 dbg_ack_out,         // taken
  input wire logic                 dbg_err_out,         // error
  input wire logic                 dbg_mem_go_out,      // access
  input wire logic                 cpu_clk_en_out,      // gate
  input wire logic                 cpu_reset_out,       // held rst
  input wire logic [15:0]          reset_vector_out,    // vector
  input wire logic                 clr_imask_out,       // pulse
  input wire logic                 stack_go_out,        // pulse
  input wire logic                 run_mode_out,        // run
  input wire logic                 bdm_out,             // bg mode
  input wire logic                 core_off_out,        // off
  input wire logic                 reg_stby_out,        // standby
  input wire logic                 adc_stby_out,        // standby
  input wire logic                 pin_hold_out,        // latched
  input wire logic [PIN_W-1:0]     pin_out              // pads
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // every request is answered on the very next cycle
  a_bus_answer: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("bus late");
  a_wait_gate: assert property ($rose(clr_imask_out) |->
    !cpu_clk_en_out && $past(cpu_clk_en_out)) else $error("wait gate");
  a_wake_stack: assert property (stack_go_out |->
    cpu_clk_en_out && !$past(cpu_clk_en_out)) else $error("wake stack");
  a_other_refused: assert property (dbg_valid_in &&
    dbg_cmd_in == DBG_OTHER && !cpu_clk_en_out |=> !dbg_ack_out)
    else $error("debug not refused");
  a_status_err: assert property (dbg_valid_in &&
    dbg_cmd_in == DBG_MEM_STATUS && !cpu_clk_en_out && !cpu_reset_out
    |=> dbg_ack_out && dbg_err_out && !dbg_mem_go_out)
    else $error("status error");
  a_halt_bdm: assert property ($rose(bdm_out) |-> cpu_clk_en_out)
    else $error("halt clock");
  a_sleep_power: assert property (core_off_out |->
    reg_stby_out && adc_stby_out && pin_hold_out) else $error("power");
  a_pins_held: assert property (pin_hold_out && $past(pin_hold_out)
    |-> $stable(pin_out)) else $error("pins moved");
  a_reset_vec: assert property ($fell(cpu_reset_out) |->
    (reset_vector_out == RESET_VECTOR_ADDR) ##[0:1]
    (run_mode_out == mode_select_pin_in)) else $error("boot");
endmodule // lpms_sequencer_sva

bind lpms_sequencer lpms_sequencer_sva lpms_sequencer_sva_i (.*);

// file: tb/lpms_cpu_model.sv
`timescale 1ns/10ps
module lpms_cpu_model (
  input  wire logic mclk_in,     // clock
  input  wire logic wait_req_in, // run one wait instruction
  input  wire logic stop_req_in, // run one stop instruction
  input  wire logic irq_req_in,  // raise an interrupt
  input  wire logic stack_go_in, // core restarted
  output logic      wait_out,    // wait strobe
  output logic      stop_out,    // stop strobe
  output logic      irq_out      // pending interrupt
);
  // the interrupt stays pending until the core restarts, so a slow
  // wake is never missed; the stop strobe is the same for latched and retained sleep
  always @(posedge mclk_in) begin
    wait_out <= wait_req_in;
    stop_out <= stop_req_in;
    irq_out  <= irq_req_in | (irq_out === 1'h1 && !stack_go_in);
  end
endmodule // lpms_cpu_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import lpms_pkg::*;
  logic mclk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic mode_select_pin_in, ext_reset_pin_n_in, ext_irq_pin_in, dv_d;
  logic cpu_wait_in, cpu_stop_in, cpu_irq_req_in, cpu_clk_en_out;
  logic cpu_reset_out, clr_imask_out, stack_go_out, run_mode_out, bdm_out;
  logic wake_irq_out, dbg_valid_in, dbg_ack_out, dbg_err_out;
  logic dbg_mem_go_out, core_off_out, reg_stby_out, adc_stby_out;
  logic pin_hold_out;
  logic [3:0]  avs_address_in;
  logic [2:0]  req, dq[$];
  logic [15:0] reset_vector_out;
  logic [7:0]  periph_pin_in, pin_out, p;
  logic [31:0] avs_writedata_in, avs_readdata_out, eq[$];
  lpms_dbg_cmd_t dbg_cmd_in;
  int error_cnt = 0;
  int cmp_count = 0;

  lpms_sequencer #(.WAKE_TICKS(8)) lpms_sequencer_i (.*);
  lpms_cpu_model lpms_cpu_model_i (.mclk_in(mclk_in), .wait_req_in(req[0]),
    .stop_req_in(req[1]), .irq_req_in(req[2]), .stack_go_in(stack_go_out),
    .wait_out(cpu_wait_in), .stop_out(cpu_stop_in),
    .irq_out(cpu_irq_req_in));

  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    cmp_count++;
    if (a !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'h0);
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    eq.push_back(e);
    bus(1'h0, a, '0);
  endtask
  task automatic dbg(input lpms_dbg_cmd_t c, input logic [2:0] e);
    dq.push_back(e);
    dbg_valid_in <= 1'h1;
    dbg_cmd_in <= c;
    @(posedge mclk_in);
    dbg_valid_in <= 1'h0;
    @(posedge mclk_in);
  endtask
  task automatic go(input logic [2:0] r);
    req <= r;
    @(posedge mclk_in);
    req <= '0;
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic boot;
    wait (cpu_reset_out === 1'h0);
    repeat (2) @(posedge mclk_in);
    cmp({15'h0, run_mode_out, reset_vector_out}, 32'h0001_fffe);
  endtask
  task automatic sleep(input logic [31:0] ctl);
    bus(1'h1, OFS_CONTROL, ctl);
    bus(1'h1, OFS_PORT, {24'h0, p});
    go(3'h2);
  endtask

  // --------------------------------------------------------------
  // clock, watchdog and result monitor
  // --------------------------------------------------------------
  initial begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end
  // the whole run needs a few hundred cycles
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
  // compare each answer with the oldest note as it appears
  always @(posedge mclk_in) begin
    if (avs_read_in === 1'h1 && avs_waitrequest_out === 1'h0)
      cmp(eq.pop_front(), avs_readdata_out);
    if (dv_d)
      cmp(32'(dq.pop_front()),
          32'({dbg_ack_out, dbg_err_out, dbg_mem_go_out}));
    dv_d <= dbg_valid_in;
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'hfd44_bdfa));
    {reset_in, mode_select_pin_in, ext_reset_pin_n_in} = 3'h7;
    {ext_irq_pin_in, avs_read_in, avs_write_in, dbg_valid_in} = 4'h8;
    {req, avs_address_in, avs_writedata_in} = '0;
    dbg_cmd_in = DBG_HALT;
    periph_pin_in = '0;
    p = 8'($urandom_range(1, 255));
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'h0;
    boot;
    rd(OFS_POWER, 32'h0000_0010);
    bus(1'h1, OFS_PORT, {24'h0, p});
    bus(1'h1, OFS_POWER, 32'h0000_0000);
    rd(OFS_POWER, 32'h0000_0010);
    rd(OFS_PORT, {24'h0, p});
    rd(4'h2, 32'h0000_0000);
    bus(1'h1, OFS_PERIPH, 32'h0000_000f);
    periph_pin_in <= 8'($urandom);
    repeat (3) @(posedge mclk_in);
    cmp({24'h0, p[7:4], periph_pin_in[3:0]}, {24'h0, pin_out});
    go(3'h1);
    dbg(DBG_OTHER, 3'h0);
    dbg(DBG_MEM_STATUS, 3'h6);
    go(3'h4);
    rd(OFS_POWER, 32'h0000_0010);
    go(3'h1);
    dbg(DBG_HALT, 3'h4);
    cmp(32'(bdm_out), 32'h0000_0001);
    dbg(DBG_MEM_STATUS, 3'h5);
    ext_reset_pin_n_in <= 1'h0;
    repeat (6) @(posedge mclk_in);
    ext_reset_pin_n_in <= 1'h1;
    boot;
    // latched sleep left by the periodic wake
    sleep(32'h0000_0034);
    cmp(32'(core_off_out), 32'h0000_0001);
    wait (wake_irq_out === 1'h1);
    boot;
    cmp(32'(pin_out), 32'(p));
    rd(OFS_POWER, 32'h0000_0011);
    bus(1'h1, OFS_POWER, 32'h0000_0002);
    rd(OFS_POWER, 32'h0000_0010);
    cmp(32'(pin_out), 32'h0000_0000);
    // detector kept alive in stop forces the retained sleep
    sleep(32'h0000_0007);
    cmp(32'({core_off_out, reg_stby_out}), 32'h0000_0001);
    ext_irq_pin_in <= 1'h0;
    wait (cpu_clk_en_out === 1'h1);
    @(posedge mclk_in);
    ext_irq_pin_in <= 1'h1;
    // interval zero: no periodic wake, pin low still wakes
    sleep(32'h0000_000c);
    repeat (200) @(posedge mclk_in);
    cmp(32'(core_off_out), 32'h0000_0001);
    ext_irq_pin_in <= 1'h0;
    wait (core_off_out === 1'h0);
    @(posedge mclk_in);
    ext_irq_pin_in <= 1'h1;
    boot;
    bus(1'h1, OFS_PORT, {24'h0, p});
    bus(1'h1, OFS_POWER, 32'h0000_0002);
    cmp(32'({pin_hold_out, pin_out}), 32'(p));
    give_verdict;
  end
endmodule // tb_top
